// File: rtl/epc_map.svh
// Purpose: Offsets, field positions and reset values of the nonvolatile array control
// Assumes: Register indices are word indices; byte address is four times the index
// Notes: Included by its bare name from the array, control and bench files
`ifndef EPC_MAP_SVH
`define EPC_MAP_SVH

// Register and array indices
`define EPC_ARRAY_BASE 16'h0800
`define EPC_NVCFG_IDX 16'hfe1c
`define EPC_CTRL_IDX 16'hfe1d
`define EPC_SHADOW_IDX 16'hfe1f

// Control register fields
`define EPC_CTRL_ERASE_HI 4
`define EPC_CTRL_ERASE_LO 3
`define EPC_CTRL_LATCH 2
`define EPC_CTRL_HV 0

// Configuration byte fields
`define EPC_CFG_REDUNDANT 7
`define EPC_CFG_LOCK_HI 3
`define EPC_CFG_LOCK_LO 0

// Values
`define EPC_ERASED 8'hff
`define EPC_NVCFG_INIT 8'h00
`define EPC_SHADOW_RESET 8'h00

`endif

// File: rtl/epc_pkg.sv
// Purpose: Types shared by the nonvolatile array control files
// Assumes: Mode codes follow the two erase-select bits, high bit first
// Notes: State codes are one-hot
package epc_pkg;

	typedef enum logic [1:0] {
		epc_byte_prog = 2'b00,
		epc_byte_erase = 2'b01,
		epc_block_erase = 2'b10,
		epc_bulk_erase = 2'b11
	} epc_mode_t;

	typedef enum logic [3:0] {
		epc_idle = 4'b0001,
		epc_armed = 4'b0010,
		epc_loaded = 4'b0100,
		epc_pumping = 4'b1000
	} epc_state_t;

endpackage

// File: rtl/epc_lock_check.sv
// Purpose: Decide whether a captured operation may have high voltage applied
// Assumes: Lock and redundant bits come from the volatile configuration shadow
// Notes: Purely combinational
`timescale 1ns/1ps
module epc_lock_check #(
	parameter int AW = 9
) (
	// Target
	input logic [AW-1:0] addr,
	input logic is_cfg,
	input epc_pkg::epc_mode_t mode,
	// Configuration
	input logic [3:0] lock,
	input logic redundant,
	// Verdict
	output logic allowed
);
	import epc_pkg::*;

	logic [3:0] lock_eff;

	always_comb begin
		lock_eff = redundant ? {2'b00, lock[1:0]} : lock;
		allowed = 1'b0;
		if (is_cfg) begin
			// config byte only by byte ops
			allowed = (mode == epc_byte_prog) || (mode == epc_byte_erase);
		end else if (mode == epc_bulk_erase) begin
			allowed = (lock_eff == 4'h0);
		end else begin
			allowed = !lock_eff[addr[AW-1:AW-2]];
		end
	end

endmodule

// File: rtl/epc_nvm_array.sv
// Purpose: Storage of the nonvolatile array and its configuration byte
// Assumes: Contents survive reset, so no reset reaches the storage
// Notes: Read is combinational; the caller registers it
`timescale 1ns/1ps
`include "epc_map.svh"
module epc_nvm_array #(
	parameter int DEPTH = 512,
	parameter int AW = 9
) (
	// Clock
	input logic clk_sys,
	// Read side
	input logic [AW-1:0] rd_addr,
	input logic redundant,
	output logic [7:0] rd_data,
	output logic [7:0] nv_cfg,
	// Operation commit
	input logic op_go,
	input epc_pkg::epc_mode_t op_mode,
	input logic [AW-1:0] op_addr,
	input logic [7:0] op_data,
	input logic op_cfg
);
	import epc_pkg::*;

	// Nonvolatile contents start erased; the config byte ships unlocked
	// Declaration values keep the clocked process as the only writer
	logic [7:0] mem [DEPTH] = '{default: `EPC_ERASED};
	logic [7:0] nv_q = `EPC_NVCFG_INIT;

	function automatic logic hit_f(input logic [AW-1:0] idx, input logic [AW-1:0] a,
			input epc_mode_t m, input logic red);
		logic [AW-1:0] f;
		f = red ? {1'b0, idx[AW-2:0]} : idx;
		case (m)
			epc_block_erase: hit_f = (f[AW-1:AW-2] == a[AW-1:AW-2]);
			epc_bulk_erase: hit_f = 1'b1;
			default: hit_f = (f == a);
		endcase
	endfunction

	always_ff @(posedge clk_sys) begin
		if (op_go && !op_cfg) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (hit_f(AW'(i), op_addr, op_mode, redundant)) begin
					if (op_mode == epc_byte_prog) begin
						mem[i] <= mem[i] & op_data;
					end else begin
						mem[i] <= `EPC_ERASED;
					end
				end
			end
		end
	end

	// config byte like an array byte
	always_ff @(posedge clk_sys) begin
		if (op_go && op_cfg) begin
			if (op_mode == epc_byte_prog) begin
				nv_q <= nv_q & op_data;
			end else if (op_mode == epc_byte_erase) begin
				nv_q <= `EPC_ERASED;
			end
		end
	end

	// two physical bytes per read when redundant
	// A bit that drifted to erased in one copy still reads programmed
	assign rd_data = redundant ? (mem[{1'b0, rd_addr[AW-2:0]}] & mem[{1'b1, rd_addr[AW-2:0]}])
		: mem[rd_addr];
	assign nv_cfg = nv_q;

endmodule

// File: rtl/epc_nvm_ctrl.sv
// Purpose: Program and erase control of the nonvolatile array behind a Wishbone slave
// Assumes: Classic Wishbone, 32-bit data, byte registers in lane 0
// Notes: Pulse length is timed by software; the block only gates the pump
//
// Operation
// - 512-byte array programmed and erased by the on-chip pump only.
// - Erased bits read one; programming only clears selected bits.
// - Operations act only on valid unlocked array bytes and config byte.
// - Redundant mode: lower-half operation also hits matching upper byte.
// - Redundant mode: lower access uses two bytes; upper half unmapped.
// - With latch set, valid array writes capture address and data, latest wins.
// - With latch set, array reads return the captured data.
// - With latch set, control writes accepted only after a capture.
// - Enable cannot be set with latch clear.
// - Enable bit switches pump and array high voltage on and off.
// - Clearing enable and latch together clears only enable.
// - Erase select: program, byte, block, bulk erase; lock suppresses.
// - Block erase clears whole block; bulk erase clears whole array.
// - Block and bulk erase leave the config byte unchanged.
// - Erase mode frozen while enable is set.
// - Locked block never erased; any lock blocks bulk erase.
// - Four 128-byte blocks ascending, lock 0 on the lowest.
// - Operation on locked block never applies high voltage.
// - Lock changes act only after reset or config byte read.
// - Redundant mode honours only the two lower lock bits.
// - Config byte copied to shadow at reset and on each read.
// - Config byte uses the same latch and enable sequence.
// - Latch cannot be cleared while enable is set.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`include "epc_map.svh"
module epc_nvm_ctrl #(
	parameter int ARRAY_BYTES = 512,
	parameter int AW = 9
) (
	// Clock and reset
	input logic clk_sys,
	input logic reset,
	// Wishbone slave
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_we_i,
	input logic [17:0] wb_adr_i,
	input logic [3:0] wb_sel_i,
	input logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Charge pump
	output logic hv_apply_o,
	output epc_pkg::epc_mode_t pump_mode_o
);
	import epc_pkg::*;

	logic [15:0] idx;
	logic [15:0] off;
	logic req;
	logic wr;
	logic rd;
	logic arr_sel;
	logic ctrl_sel;
	logic shadow_sel;
	logic cfg_sel;
	logic [7:0] wdat;
	logic ack_q;
	logic [31:0] dat_q;
	epc_state_t state_q;
	epc_state_t state_d;
	epc_mode_t erase_q;
	epc_mode_t mode_d;
	logic [AW-1:0] cap_addr_q;
	logic [7:0] cap_data_q;
	logic cap_cfg_q;
	logic [7:0] shadow_q;
	logic load_q;
	logic latched;
	logic captured;
	logic hv_bit;
	logic cap_en;
	logic ctrl_wr;
	logic ctrl_open;
	logic op_ok;
	logic op_go;
	logic hv_apply_q;
	logic redundant;
	logic [7:0] arr_rd;
	logic [7:0] nv_cfg;
	logic [7:0] ctrl_rd;

	// Address decode
	assign idx = wb_adr_i[17:2];
	assign off = idx - `EPC_ARRAY_BASE;
	assign redundant = shadow_q[`EPC_CFG_REDUNDANT];
	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign rd = req && !wb_we_i;
	assign wdat = wb_dat_i[7:0];

	always_comb begin
		arr_sel = 1'b0;
		ctrl_sel = 1'b0;
		shadow_sel = 1'b0;
		cfg_sel = 1'b0;
		// upper half not decoded when redundant
		if (off < 16'(ARRAY_BYTES) && !(redundant && off[AW-1])) begin
			arr_sel = 1'b1;
		end else if (idx == `EPC_CTRL_IDX) begin
			ctrl_sel = 1'b1;
		end else if (idx == `EPC_SHADOW_IDX) begin
			shadow_sel = 1'b1;
		end else if (idx == `EPC_NVCFG_IDX) begin
			cfg_sel = 1'b1;
		end
	end

	assign latched = (state_q != epc_idle);
	assign captured = (state_q == epc_loaded) || (state_q == epc_pumping);
	assign hv_bit = (state_q == epc_pumping);
	assign ctrl_wr = wr && ctrl_sel;
	// control writes wait for a capture
	assign ctrl_open = (state_q != epc_armed);
	// capture on valid targets while latched and enable clear
	// only array bytes and config byte are targets
	assign cap_en = wr && (arr_sel || cfg_sel) &&
		((state_q == epc_armed) || (state_q == epc_loaded));

	// erase select bits pick the operation
	assign mode_d = (ctrl_wr && ctrl_open && !hv_bit) ?
		epc_mode_t'({wdat[`EPC_CTRL_ERASE_HI], wdat[`EPC_CTRL_ERASE_LO]}) : erase_q;

	always_comb begin
		state_d = state_q;
		op_go = 1'b0;
		case (state_q)
			epc_idle: begin
				if (ctrl_wr && wdat[`EPC_CTRL_LATCH]) begin
					state_d = epc_armed;
				end
			end
			epc_armed: begin
				if (cap_en) begin
					state_d = epc_loaded;
				end
			end
			epc_loaded: begin
				if (ctrl_wr && wdat[`EPC_CTRL_HV]) begin
					state_d = epc_pumping;
					op_go = op_ok;
				end else if (ctrl_wr && !wdat[`EPC_CTRL_LATCH]) begin
					state_d = epc_idle;
				end
			end
			epc_pumping: begin
				if (ctrl_wr && !wdat[`EPC_CTRL_HV]) begin
					state_d = epc_loaded;
				end
			end
			default: begin
				state_d = epc_idle;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_q <= epc_idle;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			erase_q <= epc_byte_prog;
		end else begin
			erase_q <= mode_d;
		end
	end

	// Captured target and data
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cap_addr_q <= '0;
			cap_data_q <= 8'h00;
			cap_cfg_q <= 1'b0;
		end else if (cap_en) begin
			cap_addr_q <= off[AW-1:0];
			cap_data_q <= wdat;
			cap_cfg_q <= cfg_sel;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			hv_apply_q <= 1'b0;
		end else if (state_d != epc_pumping) begin
			hv_apply_q <= 1'b0;
		end else if (state_q != epc_pumping) begin
			hv_apply_q <= op_ok;
		end
	end

	// reload after reset and on config reads
	// Reset cannot sample the array, so the copy is taken one edge after release
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			load_q <= 1'b1;
			shadow_q <= `EPC_SHADOW_RESET;
		end else begin
			load_q <= 1'b0;
			if (load_q || (rd && cfg_sel)) begin
				shadow_q <= nv_cfg;
			end
		end
	end

	always_comb begin
		ctrl_rd = 8'h00;
		ctrl_rd[`EPC_CTRL_ERASE_HI] = erase_q[1];
		ctrl_rd[`EPC_CTRL_ERASE_LO] = erase_q[0];
		ctrl_rd[`EPC_CTRL_LATCH] = latched;
		ctrl_rd[`EPC_CTRL_HV] = hv_bit;
	end

	// Bus answer, one cycle after the request is taken
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			dat_q <= 32'h0000_0000;
		end else if (rd) begin
			dat_q <= 32'h0000_0000;
			if (arr_sel) begin
				dat_q[7:0] <= captured ? cap_data_q : arr_rd;
			end else if (ctrl_sel) begin
				dat_q[7:0] <= ctrl_rd;
			end else if (shadow_sel) begin
				dat_q[7:0] <= shadow_q;
			end else if (cfg_sel) begin
				dat_q[7:0] <= nv_cfg;
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign hv_apply_o = hv_apply_q;
	assign pump_mode_o = erase_q;

	epc_lock_check #(
		.AW(AW)
	) u_check (
		.addr(cap_addr_q),
		.is_cfg(cap_cfg_q),
		.mode(mode_d),
		.lock(shadow_q[`EPC_CFG_LOCK_HI:`EPC_CFG_LOCK_LO]),
		.redundant(redundant),
		.allowed(op_ok)
	);

	// storage written only through the pump sequence
	epc_nvm_array #(
		.DEPTH(ARRAY_BYTES),
		.AW(AW)
	) u_array (
		.clk_sys(clk_sys),
		.rd_addr(off[AW-1:0]),
		.redundant(redundant),
		.rd_data(arr_rd),
		.nv_cfg(nv_cfg),
		.op_go(op_go),
		.op_mode(mode_d),
		.op_addr(cap_addr_q),
		.op_data(cap_data_q),
		.op_cfg(cap_cfg_q)
	);

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	sequence latched_read_s;
		captured && rd && arr_sel && !hv_bit;
	endsequence

	sequence answer_s;
		##1 wb_ack_o;
	endsequence

	hv_gate_a: assert property (hv_apply_o |-> hv_bit && latched)
		else $error("high voltage applied outside an enabled latched state");

	latch_hold_a: assert property (hv_bit |=> latched)
		else $error("latch cleared while enable was set");

	mode_freeze_a: assert property (hv_bit |=> erase_q == $past(erase_q))
		else $error("erase mode changed while enable set");

	hv_refuse_a: assert property (!latched |=> !hv_bit)
		else $error("enable set without latch");

	joint_clear_a: assert property (hv_bit && ctrl_wr && !wdat[`EPC_CTRL_HV]
		&& !wdat[`EPC_CTRL_LATCH] |=> !hv_bit && latched)
		else $error("joint clear did not leave latch set");

	capture_a: assert property (cap_en && arr_sel |=> cap_addr_q == $past(off[AW-1:0])
		&& cap_data_q == $past(wdat))
		else $error("valid array write not captured");

	ctrl_block_a: assert property (state_q == epc_armed && ctrl_wr && !cap_en
		|=> state_q == epc_armed && erase_q == $past(erase_q))
		else $error("control write accepted before capture");

	latch_read_a: assert property (latched_read_s |-> answer_s
		##0 wb_dat_o[7:0] == $past(cap_data_q))
		else $error("array read while latched did not return captured data");

	shadow_load_a: assert property (rd && cfg_sel |=> shadow_q == $past(nv_cfg))
		else $error("config read did not reload shadow");

	lock_stable_a: assert property (!(rd && cfg_sel) && !load_q |=> $stable(shadow_q))
		else $error("shadow changed without reload");

	redundant_map_a: assert property (redundant && req && off[AW-1]
		&& off < 16'(ARRAY_BYTES) |-> !arr_sel)
		else $error("upper half decoded in redundant mode");

	bulk_lock_a: assert property (op_go && mode_d == epc_bulk_erase && !cap_cfg_q
		|-> shadow_q[1:0] == 2'b00 && (redundant || shadow_q[3:2] == 2'b00))
		else $error("bulk erase committed with a lock set");

	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

endmodule

// File: testbench/epc_host_model.sv
// Purpose: Wishbone master standing in for the CPU on the memory bus
// Assumes: Classic single cycles, byte data in lane 0
// Notes: Waits for ack without a limit; the bench watchdog ends a hang
`timescale 1ns/1ps
module epc_host_model (
	// Clock
	input logic clk_sys,
	// Wishbone master
	output logic wb_cyc,
	output logic wb_stb,
	output logic wb_we,
	output logic [17:0] wb_adr,
	output logic [3:0] wb_sel,
	output logic [31:0] wb_dat_w,
	input logic [31:0] wb_dat_r,
	input logic wb_ack
);
	initial begin
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 18'h0;
		wb_sel = 4'h0;
		wb_dat_w = 32'h0;
	end

	// one bus step of the host sequence
	task automatic xfer(input logic we, input logic [15:0] idx, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_sys);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= {idx, 2'b00};
		wb_sel <= 4'h1;
		wb_dat_w <= {24'h0, d};
		// Sampled before this edge's updates land
		@(posedge clk_sys iff wb_ack === 1'b1);
		q = wb_dat_r[7:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask
endmodule

// File: testbench/test_eeprom_program_erase_control.sv
// Purpose: Self-checking bench of the nonvolatile array control
// Assumes: Config byte starts at 0x00 and the array erased
// Notes: Redundant mode is entered last and never left
`timescale 1ns/1ps
`include "epc_map.svh"
module test_eeprom_program_erase_control;
	import epc_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic wb_cyc, wb_stb, wb_we, wb_ack, hv_apply;
	logic [17:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_dat_w, wb_dat_r;
	epc_mode_t pump_mode;
	int fails = 0;
	int compares = 0;
	logic [31:0] seed = 32'd49381;
	logic [7:0] m [0:511];
	logic [7:0] cfg = 8'h00;
	logic [3:0] lk = 4'h0;
	logic red = 1'b0;
	logic [7:0] q;

	always #5 clk_sys = ~clk_sys;

	epc_nvm_ctrl epc_nvm_ctrl_inst (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
		.hv_apply_o(hv_apply), .pump_mode_o(pump_mode));

	epc_host_model epc_host_model_inst (.clk_sys(clk_sys), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
		.wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
		.wb_dat_r(wb_dat_r), .wb_ack(wb_ack));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Upper locks mean nothing in redundant mode; config byte ignores locks
	function automatic logic ok_op(logic isc, logic [8:0] off, logic [1:0] md);
		logic [3:0] e;
		e = red ? {2'b00, lk[1:0]} : lk;
		if (isc)
			return md < 2'd2;
		if (md == 2'd3)
			return e == 4'h0;
		return !e[off[8:7]];
	endfunction

	task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic chk1(string what, logic exp, logic got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %b, seen %b", what, exp, got);
		end
	endtask

	task automatic wr(logic [15:0] idx, logic [7:0] d);
		epc_host_model_inst.xfer(1'b1, idx, d, q);
	endtask

	task automatic rd(logic [15:0] idx);
		epc_host_model_inst.xfer(1'b0, idx, 8'h00, q);
	endtask

	task automatic apply(logic isc, logic [8:0] off, logic [1:0] md, logic [7:0] d);
		if (isc)
			cfg = (md == 2'd0) ? cfg & d : 8'hff;
		else
			for (int i = 0; i < 512; i++)
				if (md == 2'd3 || (md == 2'd2 && (i[8:7] == off[8:7]
					|| (red && i[7] == off[7]))) || i[8:0] == off
					|| (red && !off[8] && i[8:0] == off + 9'd256))
					m[i] = (md == 2'd0) ? m[i] & d : 8'hff;
	endtask

	task automatic op(logic isc, logic [8:0] off, logic [1:0] md, logic [7:0] d);
		logic ok;
		ok = ok_op(isc, off, md);
		wr(`EPC_CTRL_IDX, {3'b000, md, 3'b100});
		wr(isc ? `EPC_NVCFG_IDX : `EPC_ARRAY_BASE + 16'(off), d);
		wr(`EPC_CTRL_IDX, {3'b000, md, 3'b101});
		chk1("hv on", ok, hv_apply);
		chk8("mode", {6'h0, md}, {6'h0, pump_mode});
		wr(`EPC_CTRL_IDX, 8'h00);
		chk1("hv off", 1'b0, hv_apply);
		rd(`EPC_CTRL_IDX);
		chk8("ctrl kept", {3'b000, md, 3'b100}, q);
		wr(`EPC_CTRL_IDX, 8'h00);
		if (ok)
			apply(isc, off, md, d);
	endtask

	task automatic chkmem(logic [8:0] off);
		rd(`EPC_ARRAY_BASE + 16'(off));
		chk8("array", (red && !off[8]) ? m[off] & m[off + 9'd256] : m[off], q);
	endtask

	task automatic wrap_up();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		wrap_up();
	end

	initial begin
		logic [8:0] off;
		logic [7:0] d;
		foreach (m[i])
			m[i] = 8'hff;
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		rd(`EPC_SHADOW_IDX);
		chk8("shadow", 8'h00, q);
		rd(16'h0100);
		chk8("unmapped", 8'h00, q);
		for (int k = 0; k < 8; k++) begin
			off = 9'(rnd());
			d = 8'(rnd());
			op(1'b0, off, 2'd0, d);
			op(1'b0, off, 2'd0, ~d);
			if (k[0])
				op(1'b0, off, 2'd1, d);
			chkmem(off);
		end
		wr(`EPC_CTRL_IDX, 8'h01);
		chk1("hv unarmed", 1'b0, hv_apply);
		wr(`EPC_CTRL_IDX, 8'h00);
		wr(`EPC_CTRL_IDX, 8'h04);
		wr(`EPC_CTRL_IDX, 8'h0c);
		rd(`EPC_CTRL_IDX);
		chk8("ctrl early", 8'h04, q);
		wr(`EPC_ARRAY_BASE + 16'h0010, 8'h11);
		wr(`EPC_ARRAY_BASE + 16'h0020, 8'h22);
		rd(`EPC_ARRAY_BASE + 16'h0030);
		chk8("latched", 8'h22, q);
		wr(`EPC_CTRL_IDX, 8'h00);
		chkmem(9'h010);
		op(1'b1, 9'h0, 2'd1, 8'h00);
		op(1'b1, 9'h0, 2'd0, 8'h01);
		rd(`EPC_SHADOW_IDX);
		chk8("shadow stale", 8'h00, q);
		rd(`EPC_NVCFG_IDX);
		chk8("config", cfg, q);
		lk = cfg[3:0];
		rd(`EPC_SHADOW_IDX);
		chk8("shadow load", 8'h01, q);
		op(1'b0, 9'h005, 2'd0, 8'h00);
		op(1'b0, 9'h005, 2'd3, 8'h00);
		op(1'b0, 9'h0c8, 2'd2, 8'h00);
		op(1'b1, 9'h0, 2'd2, 8'h00);
		op(1'b1, 9'h0, 2'd3, 8'h00);
		for (int k = 0; k < 4; k++)
			chkmem(9'(k * 100));
		rd(`EPC_NVCFG_IDX);
		chk8("config kept", 8'h01, q);
		op(1'b1, 9'h0, 2'd1, 8'h00);
		op(1'b1, 9'h0, 2'd0, 8'h80);
		rd(`EPC_NVCFG_IDX);
		red = cfg[7];
		lk = cfg[3:0];
		op(1'b0, 9'h010, 2'd0, 8'h5a);
		chkmem(9'h010);
		rd(`EPC_ARRAY_BASE + 16'h0110);
		chk8("upper", 8'h00, q);
		op(1'b1, 9'h0, 2'd1, 8'h00);
		op(1'b1, 9'h0, 2'd0, 8'h8c);
		rd(`EPC_NVCFG_IDX);
		chk8("config upper locks", cfg, q);
		red = cfg[7];
		lk = cfg[3:0];
		op(1'b0, 9'h030, 2'd2, 8'h00);
		chkmem(9'h010);
		op(1'b0, 9'h020, 2'd0, 8'h00);
		op(1'b0, 9'h0a0, 2'd3, 8'h00);
		chkmem(9'h020);
		wrap_up();
	end
endmodule
